/* File: hw/spf_serial_port.v */
// Function
// [RL1] Single-ended port offers RTS/CTS handshaking option
// [RL2] Differential port never uses hardware handshaking
// [RL3] Handshake off: RTS held asserted always
// [RL4] Handshake on: drop RTS when receiver full
// [RL5] Handshake on: transmit only while CTS asserted
// [RL6] Host ends commands with CR, optional LF
// [RL7] Command identified by first three characters
// [RL8] Case-insensitive compare except during password entry
// [RL9] Messages framed by STX and ETX
// [RL10] Every message line ends with CR LF
// [RL11] Below quarter full: send XON, raise RTS
// [RL12] Above three quarters full: send XOFF
// [RL13] Handshake on: drop RTS near 95% full
// [RL14] Host sender stops on XOFF, resumes on XON
// [RL15] Received XOFF pauses output until XON
// [RL16] XOFF while idle blocks new messages
// [RL17] Received CAN aborts pending transmission
// [RL18] Protocol selected per port
// [RL19] Binary commands only under ASCII or multidrop
// [RL20] Automatic messages on power-up and events
// [RL21] Display adapter mode flags metering responses
// [RL22] Power-up message requested after reset
// [RL23] Link runs 2400 baud, 8N1
// [RL24] One flow character per threshold crossing
// [RL25] XON, XOFF, CAN not stored
`timescale 1ns/100ps
`default_nettype none
`include "spf_consts.vh"
module spf_serial_port #(
  parameter DIFF_PORT  = 0,
  parameter BIT_CYCLES = `SPF_CLK_HZ / `SPF_BAUD
) (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        pclken,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial pins
  input  wire        rxd,
  output reg         txd,
  output reg         rts,
  input  wire        cts,
  // Event inputs, same clock
  input  wire        ev_trigger,
  input  wire        ev_group,
  input  wire        ev_selftest
);
  localparam [13:0] BIT_N  = BIT_CYCLES[13:0];
  localparam [13:0] HALF_N = BIT_CYCLES[14:1];
  localparam        HS_OK  = (DIFF_PORT == 0);
  // ****************************************
  // State
  // ****************************************
  reg  [5:0]  ctrl_r;
  reg  [5:0]  event_r;
  reg  [7:0]  rxmem [0:19];
  reg  [4:0]  wptr_r;
  reg  [4:0]  rptr_r;
  reg  [4:0]  count_r;
  reg         rx_m_r;
  reg         rx_s_r;
  reg         cts_m_r;
  reg         cts_s_r;
  reg         rx_busy_r;
  reg  [13:0] rx_cnt_r;
  reg  [3:0]  rx_bit_r;
  reg  [7:0]  rx_sh_r;
  reg         xoff_rx_r;
  reg         fc_off_r;
  reg         fc_pend_r;
  reg  [7:0]  fc_char_r;
  reg         rts_hold_r;
  reg  [1:0]  cpos_r;
  reg  [23:0] cbuf_r;
  reg  [23:0] cmd_r;
  reg         cmd_valid_r;
  reg         cmd_bin_r;
  reg         txq_full_r;
  reg  [7:0]  txq_byte_r;
  reg         txq_eol_r;
  reg         txq_eom_r;
  reg  [2:0]  tstep_r;
  reg         tx_busy_r;
  reg  [9:0]  tx_sh_r;
  reg  [3:0]  tx_bit_r;
  reg  [13:0] tx_cnt_r;
  // ****************************************
  // Decode
  // ****************************************
  wire        hs_on   = HS_OK && ctrl_r[`SPF_CTRL_HS]; // [RL1] [RL2]
  wire [1:0]  port_protocol_select   = ctrl_r[`SPF_CTRL_PORT_PROTOCOL_SELECT];
  wire        acc     = psel & penable & pready;
  wire        wr      = acc & pwrite;
  wire        rd      = acc & ~pwrite;
  wire        pop     = rd && (paddr == `SPF_OFF_RXDATA) && (count_r != 0);
  wire        rx_done = rx_busy_r && (rx_bit_r == 4'h9) &&
                        (rx_cnt_r == 14'h0000) && rx_s_r;
  wire        is_xon  = rx_sh_r == `SPF_CH_XON;
  wire        is_xoff = rx_sh_r == `SPF_CH_XOFF;
  wire        is_can  = rx_sh_r == `SPF_CH_CAN;
  wire        is_ctl  = is_xon | is_xoff | is_can;
  wire        push    = rx_done && !is_ctl && (count_r != `SPF_RX_DEPTH);
  wire        dec_on  = port_protocol_select != `SPF_PORT_PROTOCOL_SELECT_NET; // [RL18] [RL19]
  wire        cts_ok  = !hs_on || cts_s_r; // [RL5]
  wire        tx_go   = !tx_busy_r && cts_ok;
  wire        send_fc = tx_go && fc_pend_r;
  wire        send_dt = tx_go && !fc_pend_r && txq_full_r &&
                        !xoff_rx_r; // [RL15] [RL16]
  reg  [7:0]  rx_up;
  reg  [7:0]  tx_ch;
  reg  [2:0]  tstep_nxt;
  reg  [31:0] rdata_nxt;
  reg         rerr_nxt;
  wire [4:0]  count_nxt = count_r + {4'h0, push} - {4'h0, pop};
  // ****************************************
  // Combinational helpers
  // ****************************************
  always @* begin
    rx_up = rx_sh_r;
    if (!ctrl_r[`SPF_CTRL_PWD] && rx_sh_r >= `SPF_CH_LA &&
        rx_sh_r <= `SPF_CH_LZ) begin
      rx_up = rx_sh_r - `SPF_CH_CASE; // [RL8]
    end
    case (tstep_r)
      3'h0: tx_ch = `SPF_CH_STX; // [RL9]
      3'h1: tx_ch = txq_byte_r;
      3'h2: tx_ch = `SPF_CH_CR; // [RL10]
      3'h3: tx_ch = `SPF_CH_LF;
      3'h4: tx_ch = `SPF_CH_ETX; // [RL9]
      default: tx_ch = txq_byte_r;
    endcase
    case (tstep_r)
      3'h0: tstep_nxt = 3'h1;
      3'h1: tstep_nxt = (txq_eol_r | txq_eom_r) ? 3'h2 : 3'h7; // [RL10]
      3'h2: tstep_nxt = 3'h3;
      3'h3: tstep_nxt = txq_eom_r ? 3'h4 : 3'h7;
      default: tstep_nxt = 3'h7;
    endcase
    rerr_nxt  = 1'b0;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `SPF_OFF_CTRL: rdata_nxt = {26'h0, ctrl_r};
      `SPF_OFF_STATUS: rdata_nxt = {19'h0, fc_off_r, txq_full_r,
        xoff_rx_r, cts_s_r, rts, 3'h0, count_r};
      `SPF_OFF_TXDATA: rdata_nxt = 32'h0000_0000;
      `SPF_OFF_RXDATA: rdata_nxt = {23'h0, count_r != 0, rxmem[rptr_r]};
      `SPF_OFF_CMD: rdata_nxt = {6'h0, cmd_bin_r, cmd_valid_r, cmd_r};
      `SPF_OFF_EVENT: rdata_nxt = {26'h0, event_r};
      default: rerr_nxt = 1'b1;
    endcase
  end
  // ****************************************
  // Receive buffer storage
  // ****************************************
  always @(posedge pclk) begin
    if (pclken && push) begin
      rxmem[wptr_r] <= rx_sh_r;
    end
  end
  // ****************************************
  // Sequential logic
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      txd         <= 1'b1;
      rts         <= 1'b1;
      ctrl_r      <= `SPF_CTRL_RST;
      event_r     <= 6'h01; // [RL22]
      wptr_r      <= 5'h00;
      rptr_r      <= 5'h00;
      count_r     <= 5'h00;
      rx_m_r      <= 1'b1;
      rx_s_r      <= 1'b1;
      cts_m_r     <= 1'b0;
      cts_s_r     <= 1'b0;
      rx_busy_r   <= 1'b0;
      rx_cnt_r    <= 14'h0000;
      rx_bit_r    <= 4'h0;
      rx_sh_r     <= 8'h00;
      xoff_rx_r   <= 1'b0;
      fc_off_r    <= 1'b0;
      fc_pend_r   <= 1'b0;
      fc_char_r   <= 8'h00;
      rts_hold_r  <= 1'b0;
      cpos_r      <= 2'h0;
      cbuf_r      <= 24'h000000;
      cmd_r       <= 24'h000000;
      cmd_valid_r <= 1'b0;
      cmd_bin_r   <= 1'b0;
      txq_full_r  <= 1'b0;
      txq_byte_r  <= 8'h00;
      txq_eol_r   <= 1'b0;
      txq_eom_r   <= 1'b0;
      tstep_r     <= 3'h0;
      tx_busy_r   <= 1'b0;
      tx_sh_r     <= 10'h3ff;
      tx_bit_r    <= 4'h0;
      tx_cnt_r    <= 14'h0000;
    end else if (pclken) begin
      // APB: one wait state, so every read sees settled data
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= rdata_nxt;
        pslverr <= rerr_nxt;
      end
      if (wr && paddr == `SPF_OFF_CTRL) begin
        ctrl_r <= pwdata[5:0];
      end
      if (rd && paddr == `SPF_OFF_CMD) begin
        cmd_valid_r <= 1'b0;
      end
      // Event flags: clear by writing one, a new event wins
      event_r <= (wr && paddr == `SPF_OFF_EVENT) ?
                 event_r & ~pwdata[5:0] : event_r;
      if (ctrl_r[`SPF_CTRL_AUTO]) begin
        if (ev_trigger)  event_r[1] <= 1'b1; // [RL20]
        if (ev_group)    event_r[2] <= 1'b1; // [RL20]
        if (ev_selftest) event_r[3] <= 1'b1; // [RL20]
      end
      // Pin synchronisers
      rx_m_r  <= rxd;
      rx_s_r  <= rx_m_r;
      cts_m_r <= cts;
      cts_s_r <= cts_m_r;
      // Receiver, 8N1, sampled at mid bit
      if (!rx_busy_r) begin
        if (!rx_s_r) begin
          rx_busy_r <= 1'b1; // [RL23]
          rx_cnt_r  <= HALF_N;
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 14'h0000) begin
        rx_cnt_r <= rx_cnt_r - 14'h0001;
      end else begin
        rx_cnt_r <= BIT_N - 14'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rx_s_r) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r != 4'h0 && rx_bit_r != 4'h9) begin
          rx_sh_r <= {rx_s_r, rx_sh_r[7:1]};
        end else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
        end
      end
      // Received character handling
      if (rx_done) begin
        if (is_xon) xoff_rx_r <= 1'b0; // [RL15] [RL16]
        if (is_xoff) xoff_rx_r <= 1'b1; // [RL15] [RL16] [RL25]
        if (is_can) begin
          txq_full_r <= 1'b0; // [RL17] [RL25]
          event_r[4] <= 1'b1;
        end
        if (!is_ctl && dec_on) begin
          if (rx_sh_r == `SPF_CH_CR) begin
            cpos_r <= 2'h0; // [RL6]
            if (cpos_r != 2'h0) begin
              cmd_r       <= cbuf_r;
              cmd_valid_r <= 1'b1;
              cmd_bin_r   <= cbuf_r[23:16] == `SPF_CH_BIN; // [RL19]
              if (ctrl_r[`SPF_CTRL_DTA] && cbuf_r == `SPF_CMD_METER)
                event_r[5] <= 1'b1; // [RL21]
            end
          end else if (rx_sh_r != `SPF_CH_LF && cpos_r != 2'h3) begin
            // Later characters are dropped, so truncated forms match
            cpos_r <= cpos_r + 2'h1; // [RL7]
            case (cpos_r)
              2'h0: cbuf_r <= {rx_up, 16'h0000};
              2'h1: cbuf_r[15:8] <= rx_up;
              default: cbuf_r[7:0] <= rx_up;
            endcase
          end
        end
      end
      // Receive buffer pointers
      if (push) wptr_r <= (wptr_r == `SPF_RX_LAST) ? 5'h00 :
                          wptr_r + 5'h01;
      if (pop) rptr_r <= (rptr_r == `SPF_RX_LAST) ? 5'h00 :
                         rptr_r + 5'h01;
      count_r <= count_nxt;
      // Flow control with hysteresis between the two levels
      if (!fc_off_r && count_nxt > `SPF_RX_HIGH) begin
        fc_off_r  <= 1'b1; // [RL12] [RL24]
        fc_pend_r <= 1'b1;
        fc_char_r <= `SPF_CH_XOFF;
      end else if (fc_off_r && count_nxt < `SPF_RX_LOW) begin
        fc_off_r  <= 1'b0; // [RL11] [RL24]
        fc_pend_r <= 1'b1;
        fc_char_r <= `SPF_CH_XON;
      end else if (send_fc) begin
        fc_pend_r <= 1'b0;
      end
      if (count_nxt >= `SPF_RX_STOP) rts_hold_r <= 1'b1; // [RL13]
      else if (count_nxt < `SPF_RX_LOW) rts_hold_r <= 1'b0; // [RL11]
      rts <= hs_on ? !rts_hold_r : 1'b1; // [RL3] [RL4]
      // Transmit queue, one byte with framing flags
      if (wr && paddr == `SPF_OFF_TXDATA && !txq_full_r) begin
        txq_full_r <= 1'b1;
        txq_byte_r <= pwdata[7:0];
        txq_eol_r  <= pwdata[`SPF_TX_EOL];
        txq_eom_r  <= pwdata[`SPF_TX_EOM];
        tstep_r    <= pwdata[`SPF_TX_SOM] ? 3'h0 : 3'h1;
      end
      // Serialiser; flow characters go ahead of message data
      if (send_fc || send_dt) begin
        tx_busy_r <= 1'b1;
        tx_bit_r  <= 4'h0;
        tx_cnt_r  <= BIT_N - 14'h0001;
        tx_sh_r   <= {1'b1, send_fc ? fc_char_r : tx_ch, 1'b0}; // [RL23]
        txd       <= 1'b0;
        if (send_dt) begin
          tstep_r <= tstep_nxt;
          if (tstep_nxt == 3'h7) txq_full_r <= 1'b0;
        end
      end else if (tx_busy_r) begin
        if (tx_cnt_r != 14'h0000) begin
          tx_cnt_r <= tx_cnt_r - 14'h0001;
        end else if (tx_bit_r == 4'h9) begin
          tx_busy_r <= 1'b0;
          txd       <= 1'b1;
        end else begin
          tx_cnt_r <= BIT_N - 14'h0001;
          tx_bit_r <= tx_bit_r + 4'h1;
          txd      <= tx_sh_r[tx_bit_r + 4'h1];
        end
      end
    end
  end
endmodule // spf_serial_port
`default_nettype wire

/* File: hw/spf_consts.vh */
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define SPF_OFF_CTRL    12'h000
`define SPF_OFF_STATUS  12'h004
`define SPF_OFF_TXDATA  12'h008
`define SPF_OFF_RXDATA  12'h00c
`define SPF_OFF_CMD     12'h010
`define SPF_OFF_EVENT   12'h014
// ****************************************
// Control fields and reset value
// ****************************************
`define SPF_CTRL_HS     0
`define SPF_CTRL_PORT_PROTOCOL_SELECT  2:1
`define SPF_CTRL_AUTO   3
`define SPF_CTRL_DTA    4
`define SPF_CTRL_PWD    5
`define SPF_CTRL_RST    6'h08
`define SPF_PORT_PROTOCOL_SELECT_ASCII 2'h0
`define SPF_PORT_PROTOCOL_SELECT_MDROP 2'h1
`define SPF_PORT_PROTOCOL_SELECT_NET   2'h2
// ****************************************
// Transmit data flags
// ****************************************
`define SPF_TX_SOM      8
`define SPF_TX_EOL      9
`define SPF_TX_EOM      10
// ****************************************
// Characters
// ****************************************
`define SPF_CH_STX      8'h02
`define SPF_CH_ETX      8'h03
`define SPF_CH_CR       8'h0d
`define SPF_CH_LF       8'h0a
`define SPF_CH_XON      8'h11
`define SPF_CH_XOFF     8'h13
`define SPF_CH_CAN      8'h18
`define SPF_CH_BIN      8'ha5
`define SPF_CH_LA       8'h61
`define SPF_CH_LZ       8'h7a
`define SPF_CH_CASE     8'h20
`define SPF_CMD_METER   24'h4d4554
// ****************************************
// Buffer thresholds (depth 20)
// ****************************************
`define SPF_RX_DEPTH    5'h14
`define SPF_RX_LAST     5'h13
`define SPF_RX_LOW      5'h05
`define SPF_RX_HIGH     5'h0f
`define SPF_RX_STOP     5'h13
// ****************************************
// Timing
// ****************************************
`define SPF_CLK_HZ      20000000
`define SPF_BAUD        2400
`endif

/* File: tb/spf_serial_port_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module spf_properties #(
  parameter DIFF_PORT  = 0,
  parameter BIT_CYCLES = 8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclken,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial
  input wire logic        txd,
  input wire logic        rts,
  input wire logic        cts
);
  logic        hs_r;
  logic [15:0] low_r;
  wire         acc = psel && penable;
  // Shadow of handshake select, since the checker cannot see registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_r  <= 1'b0;
      low_r <= 16'h0;
    end else if (pclken) begin
      if (acc && pready && pwrite && paddr == 12'h000)
        hs_r <= pwdata[0];
      low_r <= txd ? 16'h0 : low_r + 16'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (pclken && acc && !pready |=> pready)
    else $error("pready late");
  a_apb_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property ($rose(pready) |-> $past(acc))
    else $error("pready without access");
  a_err_unmapped: assert property (
    acc && pready && paddr > 12'h014 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (
    acc && pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_rts_held: assert property (
    DIFF_PORT != 0 || !hs_r && !$past(hs_r) |-> rts)
    else $error("rts dropped with handshake off");
  a_cts_block: assert property (
    DIFF_PORT == 0 && hs_r && $past(hs_r, 4) && !cts && !$past(cts) &&
    !$past(cts, 2) && !$past(cts, 3) && !$past(cts, 4) |-> !$fell(txd))
    else $error("start bit while cts low");
  a_bit_width: assert property (
    $rose(txd) |-> low_r % BIT_CYCLES == 0)
    else $error("low run not whole bits");
endmodule // spf_properties
bind spf_serial_port spf_properties #(
  .DIFF_PORT(DIFF_PORT),
  .BIT_CYCLES(BIT_CYCLES)
) u_props (
  .pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .txd, .rts, .cts
);
`default_nettype wire

/* File: tb/spf_host.sv */
`timescale 1ns/100ps
`default_nettype none
module spf_host #(
  parameter BC = 8
) (
  // Link
  input  wire logic pclk,
  output var  logic rxd,
  input  wire logic txd
);
  logic [7:0] rq[$];
  logic       obey   = 1'b1;
  logic       paused = 1'b0;
  logic [7:0] b;
  // Line idles high between frames, as a marking UART line does
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] ch);
    // A keyboard user ignores flow control, so obey can be cleared
    while (obey && paused) @(posedge pclk);
    rxd <= 1'b0;
    repeat (BC) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= ch[i];
      repeat (BC) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BC) @(posedge pclk);
  endtask
  always begin
    @(negedge txd);
    repeat (BC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge pclk);
      b[i] = txd;
    end
    rq.push_back(b);
    if (b == 8'h13) paused = 1'b1;
    if (b == 8'h11) paused = 1'b0;
    repeat (BC) @(posedge pclk);
  end
endmodule // spf_host
`default_nettype wire

/* File: tb/tb_serial_port_flow_framing.sv */
`timescale 1ns/100ps
`default_nettype none
`include "spf_consts.vh"
module tb_serial_port_flow_framing;
  localparam logic [11:0] CT = `SPF_OFF_CTRL;
  localparam logic [11:0] ST = `SPF_OFF_STATUS;
  localparam logic [11:0] CM = `SPF_OFF_CMD;
  localparam logic [11:0] EV = `SPF_OFF_EVENT;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        pclken = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        cts = 1'b1;
  logic [2:0]  ev = 3'h0;
  logic [2:0]  v;
  logic [7:0]  c;
  logic [31:0] q;
  logic        err;
  logic [7:0]  mq[$];
  logic [7:0]  tq[$];
  wire         rxd, txd, rts, pready, pslverr;
  wire  [31:0] prdata;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          seed = 1904;
  int          n;
  always #25 pclk = ~pclk;
  spf_serial_port #(.BIT_CYCLES(8)) dut (
    .pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .rts, .cts,
    .ev_trigger(ev[0]), .ev_group(ev[1]), .ev_selftest(ev[2]));
  spf_host #(.BC(8)) host (.pclk, .rxd, .txd);
  // Differential port twin on the same bus; its rxd stays idle, but its txd sends the TXDATA writes too
  wire         d_rts, d_txd, d_rdy, d_err;
  wire  [31:0] d_rdata;
  spf_serial_port #(.DIFF_PORT(1), .BIT_CYCLES(8)) dut_diff (
    .pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata(d_rdata), .pready(d_rdy), .pslverr(d_err),
    .rxd(1'b1), .txd(d_txd), .rts(d_rts), .cts(1'b0),
    .ev_trigger(1'b0), .ev_group(1'b0), .ev_selftest(1'b0));
  // ****
  // Tasks
  // ****
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic put(input logic [31:0] d);
    do apb(0, ST, 0); while (q[11] !== 1'b0);
    apb(1, `SPF_OFF_TXDATA, d);
  endtask
  task automatic msg();
    put(32'h741);
    tq = '{8'h02, 8'h41, 8'h0d, 8'h0a, 8'h03};
  endtask
  task automatic say(input string s);
    foreach (s[k]) host.send(s[k]);
  endtask
  task automatic first();
    for (int i = 0; i < 900 && host.rq.size() == 0; i++) @(posedge pclk);
  endtask
  task automatic tx_chk();
    for (int i = 0; i < 3000 && host.rq.size() < tq.size(); i++)
      @(posedge pclk);
    repeat (100) @(posedge pclk);
    chk("tx count", tq.size(), host.rq.size());
    foreach (tq[k]) chk("tx byte", tq[k], host.rq[k]);
    tq = {};
    host.rq = {};
  endtask
  task automatic drain();
    int i = 0;
    do begin
      apb(0, `SPF_OFF_RXDATA, 0);
      if (q[8] === 1'b1 && mq.size() > 0)
        chk("rx byte", mq.pop_front(), q[7:0]);
      i++;
    end while (q[8] === 1'b1 && i < 30);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("rts", 1, rts);
    @(posedge pclk);
    apb(0, CT, 0);
    chk("ctrl", 32'h8, q);
    apb(0, EV, 0);
    chk("event", 32'h1, q);
    apb(0, 12'h020, 0);
    chk("slverr", 1, err);
    for (int a = 1; a >= 0; a--) begin
      apb(1, EV, 32'h3f);
      apb(1, CT, a << 3);
      v = 3'($random(seed));
      ev <= v;
      @(posedge pclk);
      ev <= 3'h0;
      apb(0, EV, 0);
      chk("event", a ? {v, 1'b0} : 0, q);
    end
    tq = '{`SPF_CH_STX};
    for (int k = 0; k < 3; k++) begin
      c = {3'h2, 5'($random(seed))};
      put({21'h0, 3'(1 << k), c});
      tq.push_back(c);
      if (k > 0) tq = {tq, `SPF_CH_CR, `SPF_CH_LF};
    end
    tq.push_back(`SPF_CH_ETX);
    tx_chk();
    say("mE\021tErs x\015\012");
    apb(0, CM, 0);
    chk("cmd", 32'h014d4554, q);
    drain();
    apb(1, CT, 32'h20);
    say("pAs\015");
    apb(0, CM, 0);
    chk("cmd", 32'h01704173, q);
    for (int p = 0; p < 3; p++) begin
      drain();
      apb(1, CT, p << 1);
      say("\245ab\015");
      apb(0, CM, 0);
      chk("bin", p < 2 ? 3 : 0, {q[25] & q[24], q[24]});
    end
    drain();
    apb(1, CT, 32'h18);
    say("METERING_COMMAND\015");
    apb(0, EV, 0);
    chk("dta", 1, q[5]);
    apb(1, CT, 0);
    drain();
    host.send(`SPF_CH_XON);
    host.send(`SPF_CH_CAN);
    apb(0, ST, 0);
    chk("rx count", 0, q[4:0]);
    apb(1, EV, 32'h3f);
    host.rq = {};
    host.send(`SPF_CH_XOFF);
    msg();
    repeat (300) @(posedge pclk);
    chk("blocked", 0, host.rq.size());
    host.send(`SPF_CH_XON);
    first();
    host.send(`SPF_CH_XOFF);
    repeat (100) @(posedge pclk);
    n = host.rq.size();
    repeat (300) @(posedge pclk);
    chk("paused", n, host.rq.size());
    host.send(`SPF_CH_XON);
    tx_chk();
    apb(1, CT, 1);
    cts <= 1'b0;
    msg();
    repeat (300) @(posedge pclk);
    chk("cts hold", 0, host.rq.size());
    chk("diff rts", 1, d_rts);
    cts <= 1'b1;
    tx_chk();
    put(32'h141);
    put(32'h42);
    put(32'h443);
    first();
    host.send(`SPF_CH_CAN);
    repeat (800) @(posedge pclk);
    chk("abort", 1, host.rq.size() < 7);
    apb(0, EV, 0);
    chk("can flag", 1, q[4]);
    host.rq = {};
    host.obey = 1'b0;
    for (int k = 1; k < 22; k++) begin
      c = {3'h2, 5'($random(seed))};
      host.send(c);
      if (k < 21) mq.push_back(c);
      // Count settles at end of stop bit, rts follows one cycle later
      repeat (2) @(posedge pclk);
      chk("rts", k < 19, rts);
    end
    apb(0, ST, 0);
    chk("rx count", 20, q[4:0]);
    drain();
    chk("rts", 1, rts);
    tq = '{`SPF_CH_XOFF, `SPF_CH_XON};
    tx_chk();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CT, 0);
    chk("ctrl", 32'h8, q);
    apb(0, EV, 0);
    chk("event", 32'h1, q);
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
endmodule // tb_serial_port_flow_framing
`default_nettype wire
